/* File: xim_exec.sv */
//Contract
// RULE1: A computed call first pushes its own address plus two onto the return stack.
// RULE2: The call then loads PC low from the working register and PC high and upper from latches.
// RULE3: The computed call lasts two instruction cycles, the second a no-operation.
// RULE4: The computed call leaves the working register, status flags and bank select untouched.
// RULE5: The indexed-to-file move reads at frame pointer plus the first word's 7-bit offset.
// RULE6: The indexed-to-file move writes to the 12-bit address in its 1111-prefixed second word.
// RULE7: Both moves reach the whole 4096-byte data space.
// RULE8: Software never targets the low PC byte or the stack-top bytes with either move.
// RULE9: A move whose source is an indirect-addressing register moves 00h.
// RULE10: The indexed-to-indexed move forms both addresses as frame pointer plus a 7-bit offset.
// RULE11: An indexed-to-indexed move whose destination is indirect writes nothing.
// RULE12: The literal push stores its byte at the frame pointer and then decrements it by one.
// RULE13: The literal push is decoded from 1111 1010 kkkk kkkk and takes one instruction cycle.
// RULE14: All four instructions exist only while the extended set is enabled.
// RULE15: Both moves take two cycles, read in the first, write in the last phase, set no flags.
module xim_exec (
    // Clock and reset
    input logic ref_clk,
    input logic reset,
    // Mode
    input logic ext_enable,
    // Fetch path
    input logic fetch_valid,
    input logic [15:0] fetch_word,
    input logic [20:0] pc_current,
    output logic claim,
    output logic nop_cycle,
    // Core registers
    input logic [7:0] working_register,
    input logic [7:0] pc_high_latch,
    input logic [7:0] pc_upper_latch,
    input logic [11:0] frame_pointer,
    output xim_pkg::xim_fp_wr_s fp_wr,
    // Program counter and return stack
    output xim_pkg::xim_pc_ctl_s pc_ctl,
    // Data memory
    output xim_pkg::xim_mem_req_s mem_req,
    input logic [7:0] mem_rd_data
);
    import xim_pkg::*;

    typedef struct packed {
        xim_state_e st;
        xim_op_e op;
        logic [7:0] data;
        logic [11:0] src;
        logic dest_ok;
        logic nop;
        xim_mem_req_s mem;
        xim_pc_ctl_s pc;
        xim_fp_wr_s fp;
    } xim_exec_s;

    xim_exec_s r_reg;
    xim_exec_s r_next;
    logic [1:0] q_phase;
    xim_decode_s decoded;
    logic [11:0] dest_addr;
    logic decode_hit;

    // Address falls in one of the indirect-register windows
    function automatic logic is_indirect(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            if (a >= IND_BASES[i] && a <= IND_BASES[i] + IND_SPAN_M1)
                hit = 1'b1;
        end
        return hit;
    endfunction : is_indirect

    xim_qphase u_qphase (
        .ref_clk(ref_clk),
        .reset(reset),
        .q_phase(q_phase)
    );

    xim_decode u_decode (
        .fetch_word(fetch_word),
        .ext_enable(ext_enable),
        .decoded(decoded)
    );

    // Opcode recognised in Q1 of an idle cycle
    assign decode_hit = (q_phase == PH_Q1) && fetch_valid && (decoded.op != XIM_OP_NONE);

    // Destination of the second word, 12-bit wrap over the data space
    always_comb
    begin
        if (r_reg.op == XIM_OP_MOVE_INDEXED_TO_FILE)
            dest_addr = fetch_word[11:0]; // RULE6
        else
            dest_addr = frame_pointer + {5'h00, decoded.offset}; // RULE10 RULE7
    end

    // Sequencer
    always_comb
    begin
        r_next = r_reg;
        r_next.mem.rd_en = 1'b0;
        r_next.mem.wr_en = 1'b0;
        r_next.pc.stack_push = 1'b0;
        r_next.pc.pc_load = 1'b0;
        r_next.fp.wr_en = 1'b0;
        case (r_reg.st)
            XIM_ST_IDLE:
            begin
                if (decode_hit)
                begin
                    r_next.st = XIM_ST_EXEC;
                    r_next.op = decoded.op;
                    r_next.data = decoded.literal;
                    r_next.src = frame_pointer + {5'h00, decoded.offset}; // RULE5 RULE10 RULE7
                    r_next.pc.ret_addr = pc_current + RET_ADDR_STEP; // RULE1
                end
            end
            XIM_ST_EXEC:
            begin
                case (r_reg.op)
                    XIM_OP_CALL:
                    begin
                        if (q_phase == PH_Q2)
                            r_next.pc.stack_push = 1'b1; // RULE1
                        if (q_phase == PH_Q3)
                        begin
                            // Only the PC moves; W, flags and bank select stay put
                            r_next.pc.pc_load = 1'b1; // RULE2 RULE4
                            r_next.pc.pc_target = {pc_upper_latch[4:0], pc_high_latch,
                                working_register}; // RULE2
                        end
                        if (q_phase == PH_Q4)
                        begin
                            r_next.st = XIM_ST_CALL_NOP; // RULE3
                            r_next.nop = 1'b1;
                        end
                    end
                    XIM_OP_PUSH:
                    begin
                        if (q_phase == PH_Q3)
                        begin
                            r_next.mem.wr_en = 1'b1; // RULE12
                            r_next.mem.addr = frame_pointer;
                            r_next.mem.wdata = r_reg.data;
                            r_next.fp.wr_en = 1'b1;
                            r_next.fp.value = frame_pointer - FP_STEP; // RULE12
                        end
                        if (q_phase == PH_Q4)
                            r_next.st = XIM_ST_IDLE; // RULE13
                    end
                    XIM_OP_MOVE_INDEXED_TO_FILE, XIM_OP_MOVE_INDEXED_TO_INDEXED:
                    begin
                        // Indirect sources are never read, so no side effect fires
                        if (q_phase == PH_Q3 && !is_indirect(r_reg.src))
                        begin
                            r_next.mem.rd_en = 1'b1; // RULE15
                            r_next.mem.addr = r_reg.src;
                        end
                        if (q_phase == PH_Q4)
                        begin
                            r_next.data = r_reg.mem.rd_en ? mem_rd_data
                                : SRC_INDIRECT_VALUE; // RULE9
                            r_next.st = XIM_ST_MOVE_DEST;
                        end
                    end
                    default:
                    begin
                        r_next.st = XIM_ST_IDLE;
                    end
                endcase
            end
            XIM_ST_CALL_NOP:
            begin
                if (q_phase == PH_Q4)
                begin
                    r_next.st = XIM_ST_IDLE; // RULE3
                    r_next.nop = 1'b0;
                end
            end
            XIM_ST_MOVE_DEST:
            begin
                if (q_phase == PH_Q1)
                begin
                    r_next.mem.addr = dest_addr;
                    r_next.dest_ok = fetch_valid
                        && (fetch_word[15:12] == SECOND_WORD_PREFIX) // RULE6
                        && !(r_reg.op == XIM_OP_MOVE_INDEXED_TO_INDEXED && is_indirect(dest_addr)); // RULE11
                end
                if (q_phase == PH_Q3 && r_reg.dest_ok)
                begin
                    r_next.mem.wr_en = 1'b1; // RULE15
                    r_next.mem.wdata = r_reg.data;
                end
                if (q_phase == PH_Q4)
                    r_next.st = XIM_ST_IDLE;
            end
            default:
            begin
                r_next.st = XIM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    // Outputs
    assign claim = (r_reg.st != XIM_ST_IDLE) || decode_hit; // RULE14
    assign nop_cycle = r_reg.nop;
    assign mem_req = r_reg.mem;
    assign pc_ctl = r_reg.pc;
    assign fp_wr = r_reg.fp;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Multi-step behaviours as named sequences
    sequence s_call_push;
        pc_ctl.stack_push ##1 pc_ctl.pc_load;
    endsequence

    sequence s_nop_cycle;
        nop_cycle [*4] ##1 !nop_cycle;
    endsequence

    sequence s_push_exec;
        (r_reg.st == XIM_ST_EXEC) [*3] ##1 (r_reg.st == XIM_ST_IDLE);
    endsequence

    sequence s_move_exec;
        (r_reg.st == XIM_ST_EXEC) [*3] ##1 (r_reg.st == XIM_ST_MOVE_DEST) [*4]
            ##1 (r_reg.st == XIM_ST_IDLE);
    endsequence

    a_call_push_first: assert property (pc_ctl.stack_push |-> s_call_push) // RULE1
        else $error("Call push not followed by PC load");

    a_call_ret_addr: assert property (r_reg.st == XIM_ST_IDLE && decode_hit // RULE1
        && decoded.op == XIM_OP_CALL |=> pc_ctl.ret_addr == $past(pc_current) + RET_ADDR_STEP)
        else $error("Return address is not the call address plus two");

    a_call_pc_target: assert property (pc_ctl.pc_load |-> pc_ctl.pc_target // RULE2
        == {$past(pc_upper_latch[4:0]), $past(pc_high_latch), $past(working_register)})
        else $error("Call target not built from latches and working register");

    a_call_two_cycles: assert property (pc_ctl.pc_load |=> s_nop_cycle) // RULE3
        else $error("Call second cycle not exactly one instruction cycle of no-op");

    a_nop_only_call: assert property (nop_cycle |-> r_reg.op == XIM_OP_CALL // RULE3
        && r_reg.st == XIM_ST_CALL_NOP)
        else $error("No-op cycle outside a computed call");

    a_call_no_data: assert property (r_reg.op == XIM_OP_CALL && r_reg.st != XIM_ST_IDLE // RULE4
        |-> !mem_req.wr_en && !fp_wr.wr_en)
        else $error("Computed call touched data memory or the frame pointer");

    a_push_pointer_dec: assert property (fp_wr.wr_en |-> mem_req.wr_en // RULE12
        && fp_wr.value == mem_req.addr - FP_STEP && mem_req.addr == $past(frame_pointer))
        else $error("Push store and pointer decrement disagree");

    a_push_one_cycle: assert property (r_reg.st == XIM_ST_IDLE && decode_hit // RULE13
        && decoded.op == XIM_OP_PUSH |=> s_push_exec)
        else $error("Literal push did not last one instruction cycle");

    a_move_two_cycles: assert property (r_reg.st == XIM_ST_IDLE && decode_hit // RULE15
        && (decoded.op == XIM_OP_MOVE_INDEXED_TO_FILE || decoded.op == XIM_OP_MOVE_INDEXED_TO_INDEXED) |=> s_move_exec)
        else $error("Indexed move did not last two instruction cycles");

    a_move_src_addr: assert property (mem_req.rd_en // RULE5
        |-> mem_req.addr == $past(frame_pointer, 3) + {5'h00, $past(fetch_word[6:0], 3)})
        else $error("Source address is not frame pointer plus offset");

    a_src_indirect_zero: assert property (mem_req.wr_en && r_reg.st == XIM_ST_MOVE_DEST // RULE9
        && is_indirect(r_reg.src) |-> mem_req.wdata == SRC_INDIRECT_VALUE)
        else $error("Indirect source did not move zero");

    a_move_indexed_to_indexed_dest_addr: assert property (mem_req.wr_en && r_reg.op == XIM_OP_MOVE_INDEXED_TO_INDEXED // RULE10
        |-> mem_req.addr == $past(frame_pointer, 3) + {5'h00, $past(fetch_word[6:0], 3)})
        else $error("Indexed destination is not frame pointer plus offset");

    a_move_indexed_to_indexed_dest_skip: assert property (mem_req.wr_en && r_reg.op == XIM_OP_MOVE_INDEXED_TO_INDEXED // RULE11
        |-> !is_indirect(mem_req.addr))
        else $error("Indexed move wrote an indirect destination");

    a_move_indexed_to_file_dest_lit: assert property (mem_req.wr_en && r_reg.op == XIM_OP_MOVE_INDEXED_TO_FILE // RULE6
        |-> mem_req.addr == $past(fetch_word[11:0], 3))
        else $error("File move destination differs from second word");

    a_move_read_slot: assert property (mem_req.rd_en |-> q_phase == PH_Q4 // RULE15 RULE5
        && mem_req.addr == r_reg.src)
        else $error("Source read outside its slot");

    a_write_last_phase: assert property (mem_req.wr_en |-> q_phase == PH_Q4) // RULE15
        else $error("Data write outside the final phase");

    a_ext_gate: assert property (r_reg.st == XIM_ST_IDLE && !ext_enable // RULE14
        |=> r_reg.st == XIM_ST_IDLE)
        else $error("Instruction started with extension disabled");

    a_ext_off_quiet: assert property (r_reg.st == XIM_ST_IDLE && !ext_enable // RULE14
        |-> !claim)
        else $error("Cycle claimed with extension disabled");

endmodule : xim_exec

/* File: xim_pkg.sv */
package xim_pkg;

    // Widths of the datapath
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned PC_W = 21;
    localparam int unsigned WORD_W = 16;

    // Opcode patterns
    localparam logic [15:0] OP_CALL_WORKING_REGISTER = 16'h0014;
    localparam logic [7:0] OP_MOVE_HI = 8'heb;
    localparam logic [7:0] OP_PUSH_HI = 8'hfa;
    localparam logic [3:0] SECOND_WORD_PREFIX = 4'hf;
    localparam int unsigned MOVE_KIND_BIT = 7;

    // Arithmetic steps
    localparam logic [20:0] RET_ADDR_STEP = 21'h000002;
    localparam logic [11:0] FP_STEP = 12'h001;

    // Indirect-addressing register windows, five registers each
    localparam logic [2:0][11:0] IND_BASES = {12'hfdb, 12'hfe3, 12'hfeb};
    localparam logic [11:0] IND_SPAN_M1 = 12'h004;
    localparam logic [7:0] SRC_INDIRECT_VALUE = 8'h00;

    // Q phases of one instruction cycle, four ref_clk cycles long
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [1:0] PHASE_RESET = 2'h0;

    // Instruction cycle counts
    localparam int unsigned CALL_CYCLES = 2;
    localparam int unsigned MOVE_CYCLES = 2;
    localparam int unsigned PUSH_CYCLES = 1;

    typedef enum logic [2:0] {
        XIM_OP_NONE,
        XIM_OP_CALL,
        XIM_OP_MOVE_INDEXED_TO_FILE,
        XIM_OP_MOVE_INDEXED_TO_INDEXED,
        XIM_OP_PUSH
    } xim_op_e;

    typedef enum logic [1:0] {
        XIM_ST_IDLE,
        XIM_ST_EXEC,
        XIM_ST_CALL_NOP,
        XIM_ST_MOVE_DEST
    } xim_state_e;

    typedef struct packed {
        xim_op_e op;
        logic [6:0] offset;
        logic [7:0] literal;
    } xim_decode_s;

    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [11:0] addr;
        logic [7:0] wdata;
    } xim_mem_req_s;

    typedef struct packed {
        logic stack_push;
        logic [20:0] ret_addr;
        logic pc_load;
        logic [20:0] pc_target;
    } xim_pc_ctl_s;

    typedef struct packed {
        logic wr_en;
        logic [11:0] value;
    } xim_fp_wr_s;

endpackage : xim_pkg

/* File: xim_qphase.sv */
module xim_qphase (
    // Clock and reset
    input logic ref_clk,
    input logic reset,
    // Phase of the instruction cycle
    output logic [1:0] q_phase
);
    import xim_pkg::*;

    typedef struct packed {
        logic [1:0] phase;
    } xim_qstate_s;

    xim_qstate_s q_reg;
    xim_qstate_s q_next;

    // Free-running Q1..Q4 divider
    always_comb
    begin
        q_next = q_reg;
        q_next.phase = q_reg.phase + 2'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q_reg.phase <= PHASE_RESET;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign q_phase = q_reg.phase;

endmodule : xim_qphase

/* File: xim_decode.sv */
module xim_decode (
    // Fetched word and mode
    input logic [15:0] fetch_word,
    input logic ext_enable,
    // Decoded fields
    output xim_pkg::xim_decode_s decoded
);
    import xim_pkg::*;

    // Opcode classification, gated by the extension mode
    function automatic xim_op_e op_of(input logic [15:0] w, input logic en);
        xim_op_e op;
        op = XIM_OP_NONE;
        if (en)
        begin
            if (w == OP_CALL_WORKING_REGISTER)
                op = XIM_OP_CALL;
            else if (w[15:8] == OP_MOVE_HI)
                op = w[MOVE_KIND_BIT] ? XIM_OP_MOVE_INDEXED_TO_INDEXED : XIM_OP_MOVE_INDEXED_TO_FILE;
            else if (w[15:8] == OP_PUSH_HI)
                op = XIM_OP_PUSH;
        end
        return op;
    endfunction : op_of

    // Field extraction
    always_comb
    begin
        decoded.op = op_of(fetch_word, ext_enable); // RULE14 RULE13
        decoded.offset = fetch_word[6:0];
        decoded.literal = fetch_word[7:0];
    end

endmodule : xim_decode

/* File: xim_mem_model.sv */
module xim_mem_model (
    // Clock
    input wire logic ref_clk,
    // Requests from the block
    input wire xim_pkg::xim_mem_req_s mem_req,
    input wire xim_pkg::xim_pc_ctl_s pc_ctl,
    // Read data returned to the block
    output logic [7:0] mem_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:4095];
    logic [7:0] last_rd = 8'h5a;
    logic [20:0] stack_top = 21'h000000;
    logic [20:0] pc_now = 21'h000000;
    int n_wr = 0;

    // Data only while a read is asked, else never the last value
    assign mem_rd_data = mem_req.rd_en ? mem[mem_req.addr] : ~last_rd;

    // Data memory, return stack and program counter
    always @(posedge ref_clk)
    begin
        if (mem_req.rd_en)
            last_rd <= mem[mem_req.addr];
        if (mem_req.wr_en)
        begin
            mem[mem_req.addr] <= mem_req.wdata;
            n_wr++;
        end
        if (pc_ctl.stack_push)
            stack_top <= pc_ctl.ret_addr;
        if (pc_ctl.pc_load)
            pc_now <= pc_ctl.pc_target;
    end
endmodule : xim_mem_model

/* File: xim_exec_tb.sv */
module xim_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import xim_pkg::*;
    typedef struct {
        logic ext;
        logic [15:0] w1, w2;
        logic [11:0] fp, sa;
        logic [7:0] sv, w;
        int ncl;
        logic wr;
        logic [11:0] wa;
        logic [7:0] wd;
        logic [20:0] pct;
    } xim_row_s;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic ext_enable = 1'b1;
    logic fetch_valid = 1'b0;
    logic [15:0] fetch_word = 16'h0000;
    logic [20:0] pc_current = 21'h000100;
    logic [7:0] working_register = 8'h00;
    logic [7:0] pc_high_latch = 8'h10;
    logic [7:0] pc_upper_latch = 8'he3;
    logic [11:0] frame_pointer = 12'h000;
    logic claim, nop_cycle;
    logic [7:0] mem_rd_data;
    xim_fp_wr_s fp_wr;
    xim_pc_ctl_s pc_ctl;
    xim_mem_req_s mem_req;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int base = 0;
    int n_claim, n_nop, c_wr, c_push, c_load, n_fp;
    logic [11:0] fp_val;
    // Ordinary cases; no move ever targets the pc or stack-top bytes
    xim_row_s rows [12] = '{
        '{1, 16'h0014, 16'h0000, 12'h080, 12'h000, 8'h00, 8'h06, 8, 0, 12'h0, 8'h00, 21'h031006},
        '{1, 16'hfa08, 16'h0000, 12'h1ec, 12'h000, 8'h00, 8'h00, 4, 1, 12'h1ec, 8'h08, 0},
        '{1, 16'hfa5c, 16'h0000, 12'h000, 12'h001, 8'h00, 8'h00, 4, 1, 12'h000, 8'h5c, 0},
        '{1, 16'heb05, 16'hf123, 12'h080, 12'h085, 8'h33, 8'h00, 8, 1, 12'h123, 8'h33, 0},
        '{1, 16'heb7f, 16'hf000, 12'hf80, 12'hfff, 8'ha5, 8'h00, 8, 1, 12'h000, 8'ha5, 0},
        '{1, 16'heb05, 16'hffee, 12'h080, 12'h085, 8'h77, 8'h00, 8, 1, 12'hfee, 8'h77, 0},
        '{1, 16'heb85, 16'hf786, 12'h080, 12'h085, 8'h33, 8'h00, 8, 1, 12'h086, 8'h33, 0},
        '{1, 16'heb8b, 16'hf000, 12'hfd0, 12'hfdb, 8'h99, 8'h00, 8, 1, 12'hfd0, 8'h00, 0},
        '{1, 16'heb80, 16'hf013, 12'hfd0, 12'hfd0, 8'h44, 8'h00, 8, 0, 12'h0, 8'h00, 0},
        '{1, 16'heb05, 16'he006, 12'h080, 12'h085, 8'h33, 8'h00, 8, 0, 12'h0, 8'h00, 0},
        '{0, 16'hfa11, 16'h0000, 12'h080, 12'h000, 8'h00, 8'h00, 0, 0, 12'h0, 8'h00, 0},
        '{1, 16'he800, 16'h0000, 12'h080, 12'h000, 8'h00, 8'h00, 0, 0, 12'h0, 8'h00, 0}
    };

    // Clock and a free-running clock count
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc++;

    xim_exec dut (
        .ref_clk, .reset, .ext_enable, .fetch_valid, .fetch_word, .pc_current, .claim,
        .nop_cycle, .working_register, .pc_high_latch, .pc_upper_latch, .frame_pointer,
        .fp_wr, .pc_ctl, .mem_req, .mem_rd_data
    );
    xim_mem_model partner (.ref_clk, .mem_req, .pc_ctl, .mem_rd_data);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Inputs change a little after each rising edge
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask : step

    task automatic idle_check;
        check("idle outputs", {mem_req.rd_en, mem_req.wr_en, pc_ctl.stack_push,
            pc_ctl.pc_load, fp_wr.wr_en, nop_cycle}, 0);
    endtask : idle_check

    // Find Q1 from the first claimed push after a reset
    task automatic sync;
        fetch_word = 16'hfa00;
        frame_pointer = 12'h7ff;
        ext_enable = 1'b1;
        fetch_valid = 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            #1;
            if (claim === 1'b1)
            begin
                base = cyc;
                step;
                fetch_valid = 1'b0;
                return;
            end
            step;
        end
        check("claim after reset", claim, 1);
        tally_and_finish;
    endtask : sync

    task automatic to_q1;
        for (int k = 0; k < 4 && ((cyc - base) % 4) != 0; k++)
            step;
    endtask : to_q1

    // Sample each clock from c0; a move's second word goes in at c4
    task automatic watch(input int n, input logic [15:0] w2, input logic two);
        n_claim = 0;
        n_nop = 0;
        n_fp = 0;
        c_wr = -1;
        c_push = -1;
        c_load = -1;
        for (int k = 0; k < n; k++)
        begin
            #1;
            n_claim += (claim === 1'b1);
            n_nop += (nop_cycle === 1'b1);
            if (mem_req.wr_en === 1'b1) c_wr = k;
            if (pc_ctl.stack_push === 1'b1) c_push = k;
            if (pc_ctl.pc_load === 1'b1) c_load = k;
            if (fp_wr.wr_en === 1'b1)
            begin
                n_fp++;
                fp_val = fp_wr.value;
            end
            step;
            fetch_valid = two && (k == 3);
            fetch_word = w2;
        end
    endtask : watch

    task automatic run(input xim_row_s r);
        int nw;
        logic call, push;
        call = r.ext && r.w1 == OP_CALL_WORKING_REGISTER;
        push = r.ext && r.w1[15:8] == OP_PUSH_HI;
        to_q1;
        partner.mem[r.sa] = r.sv;
        nw = partner.n_wr;
        ext_enable = r.ext;
        working_register = r.w;
        frame_pointer = r.fp;
        fetch_word = r.w1;
        fetch_valid = 1'b1;
        watch(12, r.w2, r.w1[15:8] == OP_MOVE_HI);
        check("claim clocks", n_claim, r.ncl);
        check("write count", partner.n_wr - nw, r.wr);
        if (r.wr) check("written byte", partner.mem[r.wa], r.wd);
        if (r.wr) check("write clock", c_wr, push ? 3 : 7);
        check("nop clocks", n_nop, call ? 4 : 0);
        check("fp writes", n_fp, push);
        if (push) check("new fp", fp_val, 12'(r.fp - FP_STEP));
        if (call)
        begin
            check("return addr", partner.stack_top, pc_current + RET_ADDR_STEP);
            check("push clock", c_push, 2);
            check("pc target", partner.pc_now, r.pct);
            check("load clock", c_load, 3);
        end
    endtask : run

    // Reset, the table, then a reset in mid-move
    initial
    begin
        repeat (3) step;
        idle_check;
        reset = 1'b0;
        sync;
        foreach (rows[i]) run(rows[i]);
        to_q1;
        partner.mem[12'h085] = 8'h33;
        partner.mem[12'h0aa] = 8'h3c;
        frame_pointer = 12'h080;
        fetch_word = 16'heb05;
        fetch_valid = 1'b1;
        step;
        fetch_valid = 1'b0;
        step;
        reset = 1'b1;
        step;
        idle_check;
        reset = 1'b0;
        fetch_word = 16'hf0aa;
        fetch_valid = 1'b1;
        repeat (8) step;
        check("aborted move", partner.mem[12'h0aa], 8'h3c);
        sync;
        tally_and_finish;
    end
endmodule : xim_exec_tb
